// *** hw/dac_pkg.sv ***
// package for the converter control register block
// assumes a single 100 MHz system clock and byte-wide special-function ports
`default_nettype none

package dac_pkg;

	// ==========================================================
	// port addresses and select index values
	localparam logic [7:0] SFR_LOW_ADDR   = 8'hB5;
	localparam logic [7:0] SFR_HIGH_ADDR  = 8'hB6;
	localparam logic [7:0] SFR_SEL_ADDR   = 8'hB7;
	localparam logic [7:0] SEL_CTL01      = 8'h04;
	localparam logic [7:0] SEL_CTL23      = 8'h05;

	// ==========================================================
	// field positions
	localparam int FLAG_BIT   = 7;
	localparam int DET_EN_BIT = 6;
	localparam int IDIS_BIT   = 5;
	localparam int REF_BIT    = 2;
	localparam int MODE_MSB   = 1;
	localparam int MODE_LSB   = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] CTL01_RESET = 8'h63;
	localparam logic [7:0] CTL2_RESET  = 8'h03;
	localparam logic [7:0] SEL_RESET   = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned FILTER_TIME_MS = 3;
	localparam int unsigned FILTER_CYCLES  = FILTER_TIME_MS * (CLK_HZ / 1000);
	localparam int          FILT_CNT_W     = 20;

	// ==========================================================
	// types
	typedef enum logic [1:0]
	{
		MODE_NORMAL  = 2'b00,
		MODE_PD_1K   = 2'b01,
		MODE_PD_100K = 2'b10,
		MODE_PD_HIZ  = 2'b11
	} dac_mode_e;

	typedef struct packed
	{
		logic      flag;
		logic      det_en;
		logic      idis;
		logic      ref_sel;
		dac_mode_e mode;
	} dac_ctl_s;

	typedef struct packed
	{
		logic      current_on;
		logic      ref_internal;
		dac_mode_e mode;
	} dac_analog_s;

endpackage

`default_nettype wire

// *** hw/dac_ctl_regs.sv ***
// control registers for converter channels 0, 1 and 2
// assumes the core drives sfr_addr/sfr_wr/sfr_rd/sfr_wdata on clk; comparator pins are async
//
// Functional notes
// - writing 0 to a channel's over-range flag releases it unless over-range persists; 1 is a no-op.
// - the over-range flag reads 0 until over-range is seen, then holds 1 from the 3 ms filtered or raw indication until cleared.
// - the detection enable bit switches the 3 ms over-range detection filter in (1) or out (0) and resets to 1.
// - in normal mode the disable bit turns the current output off when 1; it resets to 1.
// - the reference select picks the analog supply at 0 (reset) and the internal reference at 1.
// - output mode 00 gives normal voltage output with the current output under the disable bit.
// - modes 01, 10, 11 power the channel down with current off; 11 is the reset mode.
// - channel 1 control has the same fields and behaviour as channel 0.
// - channel 2 control has only reference select and mode; bits 7-3 read 0; reset is 03.
// - with detection disabled the over-range flag is set from the unfiltered comparator.
// - the select index chooses the register behind the two shared byte ports (04, 05).
// - channel 2 mode codes use the same encoding as the other channels.
`default_nettype none

module dac_ctl_regs
	import dac_pkg::*;
#(
	parameter int unsigned FILTER_CYCLES_P = FILTER_CYCLES
)
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [7:0]        sfr_addr,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [7:0]        sfr_wdata,
	output logic      [7:0]        sfr_rdata,
	input  wire logic [1:0]        overrange_raw,
	output logic      [1:0]        overrange_flag,
	output dac_analog_s [2:0]      analog_ctl
);

	// ==========================================================
	// decode helpers
	function automatic logic port_hit(input logic [7:0] addr, input logic [7:0] sel,
		input logic [7:0] want_addr, input logic [7:0] want_sel);
		port_hit = (addr == want_addr) && (sel == want_sel);
	endfunction

	function automatic logic [7:0] pack_ctl(input dac_ctl_s c);
		logic [7:0] v;
		v = 8'h00;
		v[FLAG_BIT]            = c.flag;
		v[DET_EN_BIT]          = c.det_en;
		v[IDIS_BIT]            = c.idis;
		v[REF_BIT]             = c.ref_sel;
		v[MODE_MSB:MODE_LSB]   = c.mode;
		pack_ctl = v;
	endfunction

	function automatic dac_analog_s drive_ch(input dac_ctl_s c);
		dac_analog_s a;
		a.current_on   = (c.mode == MODE_NORMAL) && !c.idis && !c.flag;
		a.ref_internal = c.ref_sel;
		a.mode         = c.mode;
		drive_ch = a;
	endfunction

	localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(FILTER_CYCLES_P - 1);
	localparam dac_ctl_s CTL01_RST = '{
		flag:    CTL01_RESET[FLAG_BIT],
		det_en:  CTL01_RESET[DET_EN_BIT],
		idis:    CTL01_RESET[IDIS_BIT],
		ref_sel: CTL01_RESET[REF_BIT],
		mode:    dac_mode_e'(CTL01_RESET[MODE_MSB:MODE_LSB])
	};

	// channel 2 drive after reset, no current output
	localparam dac_analog_s ANALOG2_RST = '{
		current_on:   1'b0,
		ref_internal: CTL2_RESET[REF_BIT],
		mode:         dac_mode_e'(CTL2_RESET[MODE_MSB:MODE_LSB])
	};

	// ==========================================================
	// select index
	logic [7:0] sel_r;
	logic [7:0] sel_nxt;

	always_comb
	begin
		sel_nxt = sel_r;
		if (sfr_wr && (sfr_addr == SFR_SEL_ADDR))
		begin
			sel_nxt = sfr_wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			sel_r <= SEL_RESET;
		else
			sel_r <= sel_nxt;
	end

	// ==========================================================
	// write strobes per control register
	logic [1:0] wr_ctl;
	logic       wr_ctl2;

	always_comb
	begin
		wr_ctl[0] = sfr_wr && port_hit(sfr_addr, sel_r, SFR_LOW_ADDR, SEL_CTL01);
		wr_ctl[1] = sfr_wr && port_hit(sfr_addr, sel_r, SFR_HIGH_ADDR, SEL_CTL01);
		wr_ctl2   = sfr_wr && port_hit(sfr_addr, sel_r, SFR_LOW_ADDR, SEL_CTL23);
	end

	// ==========================================================
	// channels 0 and 1: sync, filter, flag and fields
	dac_ctl_s ctl_r [2];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ch
			logic [2:0]            sync_r;
			logic [2:0]            sync_nxt;
			logic                  level_r;
			logic                  level_nxt;
			logic [FILT_CNT_W-1:0] cnt_r;
			logic [FILT_CNT_W-1:0] cnt_nxt;
			logic                  filt_r;
			logic                  filt_nxt;
			dac_ctl_s              ctl_nxt;
			logic                  detect;

			// comparator input: three stages, change once last two agree
			always_comb
			begin
				sync_nxt  = {sync_r[1:0], overrange_raw[gi]};
				level_nxt = level_r;
				if (sync_r[1] == sync_r[2])
				begin
					level_nxt = sync_r[2];
				end
			end

			// 3 ms qualification filter
			always_comb
			begin
				cnt_nxt  = cnt_r;
				filt_nxt = filt_r;
				if (!level_r)
				begin
					cnt_nxt  = '0;
					filt_nxt = 1'b0;
				end
				else if (cnt_r >= FILT_LAST)
				begin
					filt_nxt = 1'b1;
				end
				else
				begin
					cnt_nxt = cnt_r + FILT_CNT_W'(1);
				end
			end

			always_comb
			begin
				detect = ctl_r[gi].det_en ? filt_r : level_r;
			end

			// control fields and sticky flag
			always_comb
			begin
				ctl_nxt = ctl_r[gi];
				if (wr_ctl[gi])
				begin
					ctl_nxt.det_en  = sfr_wdata[DET_EN_BIT];
					ctl_nxt.idis    = sfr_wdata[IDIS_BIT];
					ctl_nxt.ref_sel = sfr_wdata[REF_BIT];
					ctl_nxt.mode    = dac_mode_e'(sfr_wdata[MODE_MSB:MODE_LSB]);
					if (!sfr_wdata[FLAG_BIT])
					begin
						ctl_nxt.flag = 1'b0;
					end
				end
				if (detect)
				begin
					ctl_nxt.flag = 1'b1;
				end
			end

			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					sync_r    <= 3'h0;
					level_r   <= 1'b0;
					cnt_r     <= '0;
					filt_r    <= 1'b0;
					ctl_r[gi] <= CTL01_RST;
				end
				else
				begin
					sync_r    <= sync_nxt;
					level_r   <= level_nxt;
					cnt_r     <= cnt_nxt;
					filt_r    <= filt_nxt;
					ctl_r[gi] <= ctl_nxt;
				end
			end
		end
	endgenerate

	// ==========================================================
	// channel 2: reference select and mode only
	logic      ref2_r;
	logic      ref2_nxt;
	dac_mode_e mode2_r;
	dac_mode_e mode2_nxt;

	always_comb
	begin
		ref2_nxt  = ref2_r;
		mode2_nxt = mode2_r;
		if (wr_ctl2)
		begin
			ref2_nxt  = sfr_wdata[REF_BIT];
			mode2_nxt = dac_mode_e'(sfr_wdata[MODE_MSB:MODE_LSB]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ref2_r  <= CTL2_RESET[REF_BIT];
			mode2_r <= dac_mode_e'(CTL2_RESET[MODE_MSB:MODE_LSB]);
		end
		else
		begin
			ref2_r  <= ref2_nxt;
			mode2_r <= mode2_nxt;
		end
	end

	// ==========================================================
	// read port and analog controls
	logic [7:0]        rdata_r;
	logic [7:0]        rdata_nxt;
	dac_analog_s [2:0] analog_r;
	dac_analog_s [2:0] analog_nxt;
	logic [1:0]        flag_r;
	logic [1:0]        flag_nxt;
	logic [7:0]        ctl2_word;

	always_comb
	begin
		ctl2_word                    = 8'h00;
		ctl2_word[REF_BIT]           = ref2_r;
		ctl2_word[MODE_MSB:MODE_LSB] = mode2_r;
		rdata_nxt = rdata_r;
		if (sfr_rd)
		begin
			rdata_nxt = 8'h00;
			if (sfr_addr == SFR_SEL_ADDR)
				rdata_nxt = sel_r;
			else if (port_hit(sfr_addr, sel_r, SFR_LOW_ADDR, SEL_CTL01))
				rdata_nxt = pack_ctl(ctl_r[0]);
			else if (port_hit(sfr_addr, sel_r, SFR_HIGH_ADDR, SEL_CTL01))
				rdata_nxt = pack_ctl(ctl_r[1]);
			else if (port_hit(sfr_addr, sel_r, SFR_LOW_ADDR, SEL_CTL23))
				rdata_nxt = ctl2_word;
		end
	end

	always_comb
	begin
		analog_nxt[0] = drive_ch(ctl_r[0]);
		analog_nxt[1] = drive_ch(ctl_r[1]);
		analog_nxt[2].current_on   = 1'b0;
		analog_nxt[2].ref_internal = ref2_r;
		analog_nxt[2].mode         = mode2_r;
		flag_nxt = {ctl_r[1].flag, ctl_r[0].flag};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_r  <= RDATA_RESET;
			analog_r[0] <= drive_ch(CTL01_RST);
			analog_r[1] <= drive_ch(CTL01_RST);
			analog_r[2] <= ANALOG2_RST;
			flag_r   <= 2'b00;
		end
		else
		begin
			rdata_r  <= rdata_nxt;
			analog_r <= analog_nxt;
			flag_r   <= flag_nxt;
		end
	end

	assign sfr_rdata      = rdata_r;
	assign analog_ctl     = analog_r;
	assign overrange_flag = flag_r;

endmodule

`default_nettype wire

// *** test/dac_ctl_regs_sva.sv ***
// checker for the converter control register block
// assumes it is bound to dac_ctl_regs and sees only its ports
`default_nettype none
module dac_ctl_regs_sva
	import dac_pkg::*;
#(
	parameter int unsigned FILTER_CYCLES_P = FILTER_CYCLES
)
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [7:0]        sfr_addr,
	input wire logic              sfr_wr,
	input wire logic              sfr_rd,
	input wire logic [7:0]        sfr_wdata,
	input wire logic [7:0]        sfr_rdata,
	input wire logic [1:0]        overrange_raw,
	input wire logic [1:0]        overrange_flag,
	input wire dac_analog_s [2:0] analog_ctl
);
	// ==========
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_rd_unmapped: assert property (sfr_rd && (sfr_addr < 8'hB5 || sfr_addr > 8'hB7)
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_unused_zero: assert property (sfr_rd && sfr_addr != SFR_SEL_ADDR
		|=> sfr_rdata[4:3] == 2'h0) else $error("unused bits read set");
	a_ch2_no_cur: assert property (!analog_ctl[2].current_on)
		else $error("channel 2 current on");
	a_pd_cur_off: assert property (analog_ctl[0].mode != MODE_NORMAL
		|-> !analog_ctl[0].current_on) else $error("ch0 current on in power-down");
	a_pd_cur_one: assert property (analog_ctl[1].mode != MODE_NORMAL
		|-> !analog_ctl[1].current_on) else $error("ch1 current on in power-down");
	a_flag_no_raw: assert property ((!overrange_raw[0])[*8]
		|=> !$rose(overrange_flag[0])) else $error("flag rose without over-range");
	a_flag_sticky: assert property ($fell(overrange_flag[0]) |-> $past(sfr_wr, 2)
		&& $past(sfr_addr, 2) == SFR_LOW_ADDR && !$past(sfr_wdata[7], 2))
		else $error("flag fell without a clearing write");
	c_flag_set: cover property ($rose(overrange_flag[0]));
	c_flag_clr: cover property ($fell(overrange_flag[0]));
	c_cur_on: cover property (analog_ctl[0].current_on);
endmodule
bind dac_ctl_regs dac_ctl_regs_sva #(.FILTER_CYCLES_P(FILTER_CYCLES_P)) dac_ctl_regs_sva_inst
	(.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .overrange_raw(overrange_raw),
	.overrange_flag(overrange_flag), .analog_ctl(analog_ctl));
`default_nettype wire

// *** test/dac_analog_model.sv ***
// comparator side of the analog output stages for channels 0 and 1
// assumes the bench commands a load fault per channel
`default_nettype none
module dac_analog_model
(
	input  wire logic  clk,
	input  wire logic [1:0] fault,
	output logic [1:0] overrange_raw
);
	// ==========
	// over-range level follows the load a cycle late
	always_ff @(posedge clk)
		overrange_raw <= fault;
endmodule
`default_nettype wire

// *** test/dac_ctl_regs_tb_top.sv ***
// bench for the converter control register block
// assumes package, design, checker and analog model compiled first
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module dac_ctl_regs_tb_top
	import dac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk;
	logic              rst;
	logic              wr;
	logic              rd;
	logic [7:0]        addr;
	logic [7:0]        wdata;
	logic [7:0]        rdata;
	logic [1:0]        raw;
	logic [1:0]        flag;
	logic [1:0]        fault;
	dac_analog_s [2:0] actl;
	int                fail_count = 0;
	int                checks = 0;
	dac_ctl_regs #(.FILTER_CYCLES_P(8)) dac_ctl_regs_inst (.clk(clk), .rst(rst),
		.sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
		.overrange_raw(raw), .overrange_flag(flag), .analog_ctl(actl));
	dac_analog_model dac_analog_model_inst (.clk(clk), .fault(fault), .overrange_raw(raw));
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// ==========
	// bus tasks
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'h1;
		@(negedge clk);
		wr = 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'h1;
		@(negedge clk);
		rd = 1'h0;
		`CHK(rdata, e)
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		`CHK(actl, 12'h333)
		`CHK(flag, 2'h0)
		rd_chk(SFR_SEL_ADDR, 8'h00);
		rd_chk(SFR_LOW_ADDR, 8'h00);
		wr_reg(SFR_SEL_ADDR, SEL_CTL01);
		rd_chk(SFR_LOW_ADDR, 8'h63);
		rd_chk(SFR_HIGH_ADDR, 8'h63);
		wr_reg(SFR_SEL_ADDR, SEL_CTL23);
		rd_chk(SFR_LOW_ADDR, 8'h03);
		rd_chk(SFR_HIGH_ADDR, 8'h00);
		rd_chk(8'hB8, 8'h00);
	endtask
	task automatic t_modes;
		logic [7:0] a;
		logic [7:0] k;
		for (int c = 0; c < 3; c++)
		begin
			a = (c == 1) ? SFR_HIGH_ADDR : SFR_LOW_ADDR;
			k = (c == 2) ? 8'h04 : 8'h44;
			wr_reg(SFR_SEL_ADDR, (c == 2) ? SEL_CTL23 : SEL_CTL01);
			for (int m = 0; m < 4; m++)
			begin
				wr_reg(a, 8'h44 | 8'(m));
				rd_chk(a, k | 8'(m));
				idle(1);
				`CHK(actl[c], {c < 2 && m == 0, 1'h1, 2'(m)})
			end
			wr_reg(a, 8'h64);
			idle(3);
			`CHK(actl[c].current_on, 1'h0)
			wr_reg(a, 8'hFF);
			rd_chk(a, (c == 2) ? 8'h07 : 8'h67);
		end
	endtask
	task automatic t_over;
		wr_reg(SFR_SEL_ADDR, SEL_CTL01);
		wr_reg(SFR_LOW_ADDR, 8'h00);
		fault = 2'h1;
		idle(8);
		`CHK(flag, 2'h1)
		`CHK(actl[0].current_on, 1'h0)
		rd_chk(SFR_LOW_ADDR, 8'h80);
		wr_reg(SFR_LOW_ADDR, 8'h00);
		idle(3);
		`CHK(flag, 2'h1)
		fault = 2'h0;
		idle(8);
		wr_reg(SFR_LOW_ADDR, 8'h80);
		idle(3);
		`CHK(flag, 2'h1)
		wr_reg(SFR_LOW_ADDR, 8'h00);
		idle(3);
		`CHK(actl[0], 4'h8)
		wr_reg(SFR_LOW_ADDR, 8'h40);
		fault = 2'h1;
		idle(4);
		fault = 2'h0;
		idle(10);
		`CHK(flag, 2'h0)
		fault = 2'h1;
		idle(20);
		`CHK(flag, 2'h1)
		fault = 2'h0;
	endtask
	task automatic t_over_ch1;
		wr_reg(SFR_SEL_ADDR, SEL_CTL01);
		wr_reg(SFR_HIGH_ADDR, 8'h00);
		fault = 2'h2;
		idle(8);
		`CHK(flag[1], 1'h1)
		`CHK(actl[1].current_on, 1'h0)
		rd_chk(SFR_HIGH_ADDR, 8'h80);
		fault = 2'h0;
		idle(8);
		wr_reg(SFR_HIGH_ADDR, 8'h00);
		idle(3);
		`CHK(actl[1], 4'h8)
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		rst = 1'h1;
		wr = 1'h0;
		rd = 1'h0;
		addr = 8'h00;
		wdata = 8'h00;
		fault = 2'h0;
		idle(5);
		rst = 1'h0;
		t_reset;
		t_modes;
		t_over;
		t_over_ch1;
		rst = 1'h1;
		idle(5);
		rst = 1'h0;
		t_reset;
		report_and_stop;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
